/* hw/erc_ext_regs.sv */
// Extended register bank: extended RAM access, control registers, recovery stack
`timescale 1ns/1ps

// Overview of operation
// RQ1 - Host selects bank one before access
// RQ2 - Address low at 50h, high at 51h
// RQ3 - Data port 53h reads/writes addressed byte
// RQ4 - Burst increments on strobe rise, 53h only
// RQ5 - Bit 5 enables burst auto-increment
// RQ6 - Bit 7 shows auxiliary battery good
// RQ7 - Update status leads update by 122us
// RQ8 - Bit 3 zero drives power output low
// RQ9 - Enabled wake-up or kickstart clears bit 3
// RQ10 - RAM-clear flag set, cleared, forced by write
// RQ11 - Wake-up flag set by alarm or write
// RQ12 - Kickstart flag set by event or write
// RQ13 - Reserved bit is plain storage
// RQ14 - Oscillator output enable forced on at power-up
// RQ15 - Crystal select picks 6pF or 12.5pF
// RQ16 - Enabled RAM-clear input clears user RAM
// RQ17 - Power fail releases output unless selected
// RQ18 - RAM-clear interrupt when enabled
// RQ19 - Enabled wake-up drives power and interrupt
// RQ20 - Enabled kickstart drives power and interrupt
// RQ21 - Address latch pushes recovery stack
// RQ22 - Stack keeps current plus three previous
// RQ23 - Kickstart low pulse at least 2us
// RQ24 - Burst address carries low into high
module erc_ext_regs
    import erc_pkg::*;
#(
    parameter int XADDR_W  = XADDR_W_DEF,   // Extended RAM address width
    parameter int LEAD_CYC = UIP_LEAD_CYC,  // Update lead in cycles
    parameter int KS_CYC   = KS_MIN_CYC     // Kickstart least width in cycles
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] ad_i,             // Multiplexed address/data in
    output logic      [7:0] ad_o,             // Read data out
    output logic            ad_oe_o,          // Drives the data bus
    input  wire logic       ale_i,            // Address latch strobe
    input  wire logic       rd_n_i,           // Read strobe, active low
    input  wire logic       wr_n_i,           // Write strobe, active low
    input  wire logic       cs_n_i,           // Chip select, active low
    input  wire logic       bank_select_bit_i,// Bank one selected
    input  wire logic       power_good_signal_i,  // Main supply present
    input  wire logic       aux_battery_pin_ok_i, // Auxiliary battery good
    input  wire logic       update_req_i,     // Clock core wants an update
    input  wire logic       update_done_i,    // Update cycle finished
    input  wire logic       wakeup_match_i,   // Wake-up alarm match pulse
    input  wire logic       kickstart_input_n_i, // Kickstart pin, active low
    input  wire logic       ram_clear_input_n_i, // RAM-clear pin, active low
    output logic            update_start_o,   // Update cycle may begin
    output logic            user_ram_clear_o, // Clear the 114 user bytes
    output logic            power_control_output_o,    // Always low level
    output logic            power_control_output_oe_o, // Pulls power pin low
    output logic            irq_o,            // Always low level
    output logic            irq_oe_o,         // Pulls interrupt pin low
    output logic            osc_output_enable_o, // Square wave is 32.768 kHz
    output logic            xtal_load_sel_o,  // Crystal load select
    output logic            aux_battery_enable_o // Auxiliary battery enable
);

    localparam int HI_W = XADDR_W - 8;        // Width of the high address byte

    // Register state
    erc_ctrl_a_t          ctl_a_q;            // Extended control/status A
    erc_ctrl_b_t          ctl_b_q;            // Extended control B
    logic [XADDR_W-1:0]   xaddr_q;            // Extended RAM address counter
    logic [7:0]           stk_q [STK_DEPTH];  // Recovery stack, 0 is current
    logic [7:0]           xram [2**XADDR_W];  // Extended battery-backed RAM
    logic [7:0]           rdata_q;            // Read data held for the bus
    erc_upd_state_t       upd_q;              // Update status sequencer
    logic [31:0]          upd_cnt_q;          // Lead counter
    logic [31:0]          ks_cnt_q;           // Kickstart low-time counter

    // Strobe, supply and RAM-clear pin history for edge detection
    logic       ale_q;
    logic       rd_n_q;
    logic       wr_n_q;
    logic       vcc_q;
    logic       rcl_n_q;
    logic [7:0] ad_q;                         // Bus value one cycle back

    // Access qualifiers
    logic sel;                                // Bank one chip access
    logic ale_fall;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic wr_a;                               // Write to control A
    logic wr_b;                               // Write to control B
    logic data_edge;                          // Strobe end at data port
    logic wake_hit;                           // Enabled wake-up pending
    logic kick_hit;                           // Enabled kickstart pending
    logic rcl_fall;
    logic ks_event;

    // Read multiplexer, used for the held read data
    function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        if (ofs == OFS_CTRL_A) begin
            v = ctl_a_q;
        end else if (ofs == OFS_CTRL_B) begin
            v = ctl_b_q;
        end else if (ofs == OFS_STK_0) begin
            v = stk_q[2];
        end else if (ofs == OFS_STK_1) begin
            v = stk_q[1];
        end else if (ofs == OFS_XADR_L) begin
            v = xaddr_q[7:0];
        end else if (ofs == OFS_XADR_H) begin
            // High bits right-justified, unused bits read zero
            v = {{(16 - XADDR_W){1'b0}}, xaddr_q[XADDR_W-1:8]};
        end else if (ofs == OFS_XDATA) begin
            v = xram[xaddr_q];
        end
        return v;
    endfunction

    // Reads and writes are ignored unless the host has set the bank bit
    // RQ1 bank select gate
    assign sel       = !cs_n_i && bank_select_bit_i;
    assign ale_fall  = ale_q && !ale_i;
    assign rd_fall   = !rd_n_i && rd_n_q;
    assign rd_rise   = rd_n_i && !rd_n_q;
    assign wr_rise   = wr_n_i && !wr_n_q;
    assign wr_a      = sel && wr_rise && stk_q[0] == OFS_CTRL_A;
    assign wr_b      = sel && wr_rise && stk_q[0] == OFS_CTRL_B;
    assign data_edge = sel && (rd_rise || wr_rise) && stk_q[0] == OFS_XDATA;
    assign rcl_fall  = rcl_n_q && !ram_clear_input_n_i;
    assign ks_event  = !kickstart_input_n_i && ks_cnt_q == 32'(KS_CYC - 1);
    // RQ19 wake-up enable gate
    assign wake_hit  = ctl_a_q.wakeup_flag && ctl_b_q.wakeup_enable;
    // RQ20 kickstart enable gate
    assign kick_hit  = ctl_a_q.kickstart_flag && ctl_b_q.kickstart_enable;

    // Edge history, sampled every cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ale_q   <= 1'b0;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            // Supply taken as present, so leaving reset is no false power-up edge
            vcc_q   <= 1'b1;
            rcl_n_q <= 1'b1;
            ad_q    <= 8'h00;
        end else begin
            ale_q   <= ale_i;
            rd_n_q  <= rd_n_i;
            wr_n_q  <= wr_n_i;
            vcc_q   <= power_good_signal_i;
            rcl_n_q <= ram_clear_input_n_i;
            ad_q    <= ad_i;
        end
    end

    // Recovery stack, address taken from the bus while the latch was open
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_q[i] <= 8'h00;
            end
        end else if (ale_fall) begin
            // RQ21 latch and push
            stk_q[0] <= ad_q;
            // RQ22 oldest entry drops
            for (int i = 1; i < STK_DEPTH; i++) begin
                stk_q[i] <= stk_q[i-1];
            end
        end
    end

    // Extended RAM address counter
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xaddr_q <= '0;
        end else if (sel && wr_rise && stk_q[0] == OFS_XADR_L) begin
            // RQ2 low address byte
            xaddr_q[7:0] <= ad_q;
        end else if (sel && wr_rise && stk_q[0] == OFS_XADR_H) begin
            // RQ2 high bits right-justified
            xaddr_q[XADDR_W-1:8] <= ad_q[HI_W-1:0];
        end else if (data_edge && ctl_a_q.burst_enable) begin
            // RQ4 increment at strobe end
            // RQ5 burst enable steers it
            // RQ24 one counter across both bytes
            xaddr_q <= xaddr_q + XADDR_W'(1);
        end
    end

    // Extended RAM storage; no reset, contents are battery-backed
    always_ff @(posedge clk_i) begin
        // RQ3 data port write
        if (data_edge && wr_rise) begin
            xram[xaddr_q] <= ad_q;
        end
    end

    // Read data captured at the start of a read, held for the whole strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else if (sel && rd_fall) begin
            // RQ3 data port read
            rdata_q <= rd_mux(stk_q[0]);
        end
    end

    // Bus driven only while a selected read is under way
    assign ad_o    = rdata_q;
    assign ad_oe_o = sel && !rd_n_i && !rd_n_q;

    // Control/status A: flags where a hardware set beats a software clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_a_q <= RST_CTRL_A;
        end else begin
            // RQ6 battery status tracks the pin
            ctl_a_q.aux_battery_valid <= aux_battery_pin_ok_i;
            // RQ7 status high through lead and update
            ctl_a_q.update_in_progress <= (upd_q != UPD_IDLE);
            if (wr_a) begin
                ctl_a_q.burst_enable <= ad_q[5];
                // RQ13 reserved storage
                ctl_a_q.rsvd <= ad_q[4];
            end
            // RQ9 enabled event clears release
            if (wake_hit || kick_hit) begin
                ctl_a_q.power_output_release <= 1'b0;
            end else if (wr_a) begin
                ctl_a_q.power_output_release <= ad_q[3];
            end else if (vcc_q && !power_good_signal_i
                         && !ctl_b_q.power_fail_output_select) begin
                // RQ17 release on power fail
                ctl_a_q.power_output_release <= 1'b1;
            end
            // RQ10 set on enabled falling edge
            if (rcl_fall && ctl_b_q.ram_clear_enable) begin
                ctl_a_q.ram_clear_flag <= 1'b1;
            end else if (wr_a) begin
                ctl_a_q.ram_clear_flag <= ad_q[2];
            end
            // RQ11 alarm or write sets
            if (wakeup_match_i) begin
                ctl_a_q.wakeup_flag <= 1'b1;
            end else if (wr_a) begin
                ctl_a_q.wakeup_flag <= ad_q[1];
            end
            // RQ12 event or write sets
            if (ks_event) begin
                ctl_a_q.kickstart_flag <= 1'b1;
            end else if (wr_a) begin
                ctl_a_q.kickstart_flag <= ad_q[0];
            end
        end
    end

    // Control B, plain storage plus power-up override
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_b_q <= RST_CTRL_B;
        end else begin
            if (wr_b) begin
                ctl_b_q <= ad_q;
            end
            // RQ14 forced on at supply rise
            if (!vcc_q && power_good_signal_i) begin
                ctl_b_q.osc_output_enable <= 1'b1;
            end
        end
    end

    // Kickstart pin must stay low long enough before it counts
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ks_cnt_q <= '0;
        end else if (kickstart_input_n_i) begin
            ks_cnt_q <= '0;
        end else if (ks_cnt_q < 32'(KS_CYC)) begin
            // RQ23 least pulse width
            ks_cnt_q <= ks_cnt_q + 32'd1;
        end
    end

    // Update sequencer: status rises a full lead before the update starts
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upd_q     <= UPD_IDLE;
            upd_cnt_q <= '0;
        end else begin
            case (upd_q)
                UPD_IDLE: begin
                    upd_cnt_q <= '0;
                    if (update_req_i) begin
                        upd_q <= UPD_LEAD;
                    end
                end
                UPD_LEAD: begin
                    // RQ7 lead count
                    upd_cnt_q <= upd_cnt_q + 32'd1;
                    if (upd_cnt_q == 32'(LEAD_CYC)) begin
                        upd_q <= UPD_RUN;
                    end
                end
                UPD_RUN: begin
                    if (update_done_i) begin
                        upd_q <= UPD_IDLE;
                    end
                end
                default: begin
                    upd_q <= UPD_IDLE;
                end
            endcase
        end
    end

    // One-cycle pulse as the lead ends; status bit lags the state by one cycle,
    // so the count runs one step further to keep the full lead
    assign update_start_o = (upd_q == UPD_LEAD) && upd_cnt_q == 32'(LEAD_CYC);

    // RQ16 clear held while enabled input low
    assign user_ram_clear_o = ctl_b_q.ram_clear_enable && !ram_clear_input_n_i;

    // RQ8 open-drain power output
    assign power_control_output_o    = 1'b0;
    assign power_control_output_oe_o = !ctl_a_q.power_output_release;

    // RQ18 interrupt from RAM clear
    // RQ19 interrupt from wake-up with supply
    assign irq_o    = 1'b0;
    assign irq_oe_o = power_good_signal_i && (wake_hit || kick_hit
                      || (ctl_a_q.ram_clear_flag && ctl_b_q.ram_clear_irq_enable));

    // RQ15 crystal load select out
    assign xtal_load_sel_o      = ctl_b_q.xtal_load_sel;
    assign osc_output_enable_o  = ctl_b_q.osc_output_enable;
    assign aux_battery_enable_o = ctl_b_q.aux_battery_enable;

    // Checks kept beside the logic
    a_pab_auto_clear: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
        (wake_hit || kick_hit) |=> power_control_output_oe_o)
        else $error("power output not pulled after enabled event");
    a_burst_step: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
        (data_edge && ctl_a_q.burst_enable) |=> xaddr_q == $past(xaddr_q) + XADDR_W'(1))
        else $error("burst address did not step");
    a_burst_off_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
        (data_edge && !ctl_a_q.burst_enable) |=> $stable(xaddr_q))
        else $error("address moved with burst off");
    a_stack_push: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ22
        ale_fall |=> stk_q[1] == $past(stk_q[0]) && stk_q[3] == $past(stk_q[2]))
        else $error("recovery stack did not shift");
    a_stack_latch: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ21
        ale_fall |=> stk_q[0] == $past(ad_q))
        else $error("address not latched");
    a_uip_lead: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ7
        (upd_q == UPD_IDLE && update_req_i) |=> !update_start_o [*8] ##1
        ctl_a_q.update_in_progress)
        else $error("update started without lead");
    a_rf_set: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ10
        (rcl_fall && ctl_b_q.ram_clear_enable) |=> ctl_a_q.ram_clear_flag ##1 irq_oe_o
        || !power_good_signal_i || !ctl_b_q.ram_clear_irq_enable)
        else $error("RAM clear flag not set");
    a_wake_irq: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ19
        (wakeup_match_i && ctl_b_q.wakeup_enable && power_good_signal_i)
        |=> ##1 (irq_oe_o || !power_good_signal_i || !ctl_b_q.wakeup_enable
        || !ctl_a_q.wakeup_flag))
        else $error("wake-up did not raise interrupt");
    a_osc_powerup: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ14
        (!vcc_q && power_good_signal_i) |=> osc_output_enable_o)
        else $error("oscillator output not forced at power-up");

endmodule

/* hw/erc_pkg.sv */
// Constants, register layouts and timing for the extended register bank
package erc_pkg;

    // Register offsets inside bank one
    localparam logic [7:0] OFS_CTRL_A = 8'h4A;     // Extended control/status A
    localparam logic [7:0] OFS_CTRL_B = 8'h4B;     // Extended control B
    localparam logic [7:0] OFS_STK_0  = 8'h4E;     // Recovery stack, two back
    localparam logic [7:0] OFS_STK_1  = 8'h4F;     // Recovery stack, one back
    localparam logic [7:0] OFS_XADR_L = 8'h50;     // Extended RAM address low
    localparam logic [7:0] OFS_XADR_H = 8'h51;     // Extended RAM address high
    localparam logic [7:0] OFS_XDATA  = 8'h53;     // Extended RAM data port

    // Reset values of the control registers
    localparam logic [7:0] RST_CTRL_A = 8'h08;     // Power output released
    localparam logic [7:0] RST_CTRL_B = 8'h00;     // All functions off

    // Default extended RAM address width (8k bytes)
    localparam int XADDR_W_DEF = 13;
    // Recovery stack depth
    localparam int STK_DEPTH   = 4;

    // Timing, clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    localparam int UIP_LEAD_NS   = 122000;         // Status lead before update
    localparam int KS_MIN_NS     = 2000;           // Least kickstart low pulse
    // Least times round up to whole cycles
    localparam int UIP_LEAD_CYC  = (UIP_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int KS_MIN_CYC    = (KS_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Extended control/status A layout, MSB first
    typedef struct packed {
        logic aux_battery_valid;   // Read-only battery status
        logic update_in_progress;  // Read-only update status
        logic burst_enable;        // Address auto-increment
        logic rsvd;                // Plain storage
        logic power_output_release;// 1 releases the power output
        logic ram_clear_flag;      // RAM clear done
        logic wakeup_flag;         // Wake-up alarm seen
        logic kickstart_flag;      // Kickstart seen
    } erc_ctrl_a_t;

    // Extended control B layout, MSB first
    typedef struct packed {
        logic aux_battery_enable;       // Enables auxiliary battery functions
        logic osc_output_enable;        // 32.768 kHz on square-wave pin
        logic xtal_load_sel;            // 0: 6 pF, 1: 12.5 pF crystal
        logic ram_clear_enable;         // Arms the RAM clear input
        logic power_fail_output_select; // Keep power output on power fail
        logic ram_clear_irq_enable;     // RAM clear interrupt enable
        logic wakeup_enable;            // Wake-up enable
        logic kickstart_enable;         // Kickstart enable
    } erc_ctrl_b_t;

    // Update status sequencer states
    typedef enum logic [1:0] {
        UPD_IDLE,
        UPD_LEAD,
        UPD_RUN
    } erc_upd_state_t;

endpackage

/* dv/erc_host.sv */
// Host model for the multiplexed register bus
`timescale 1ns/1ps
module erc_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,  // Resolved bus level
    output logic      [7:0] ad_o,   // Host drive, inverted once released
    output logic            ale_o,  // Address latch strobe
    output logic            rd_n_o, // Read strobe
    output logic            wr_n_o, // Write strobe
    output logic            cs_n_o  // Chip select
);
    // Idle bus at time zero
    initial begin
        ad_o   = 8'h00;
        ale_o  = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
    end

    // Signals move one ns after the edge
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    // Latch, strobe low two cycles, sample, release
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        step();
        ale_o = 1'b1;
        ad_o  = a;
        step();
        ale_o = 1'b0;
        step();
        cs_n_o = 1'b0;
        if (wr) begin
            wr_n_o = 1'b0;
            ad_o   = d;
        end else begin
            rd_n_o = 1'b0;
            ad_o   = ~a; // Stale level must not pass for read data
        end
        step();
        @(posedge clk_i);
        q = bus_i;
        #1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        ad_o   = ~ad_o;
        // Select holds through the strobe-rise edge that takes the access
        step();
        cs_n_o = 1'b1;
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the extended register bank
`timescale 1ns/1ps
module tb import erc_pkg::*;;
    localparam int LEAD = 20; // Shortened update lead
    localparam int KSC  = 4;  // Shortened kickstart width
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } erc_row_t;
    logic       clk_i  = 1'b0;
    logic       rstn_i = 1'b0;
    logic [7:0] h_ad, d_ad, bus, q; // Host drive, device drive, wire
    logic       d_oe, ale, rd_n, wr_n, cs_n;
    logic       bank = 1'b0, pgood = 1'b1, ureq = 1'b0, udone = 1'b0;
    logic       wake = 1'b0, ks_n = 1'b1, ram_clear_input_n = 1'b1;
    logic       ustart, uclr, power_control_output, pwr_oe, irq, irq_oe, osc, xtal, abe;
    int         n_mismatch = 0, checks = 0, cyc = 0, n;
    // Plain write and read-back cases
    erc_row_t   rows [6] = '{'{OFS_CTRL_A, 8'h18, 8'h98}, '{OFS_CTRL_A, 8'h08, 8'h88},
                             '{OFS_XADR_H, 8'hFF, 8'h1F}, '{OFS_XADR_L, 8'h3C, 8'h3C},
                             '{8'h52, 8'hFF, 8'h00}, '{OFS_CTRL_B, 8'hA0, 8'hA0}};

    // Device drive wins while it reads out
    assign bus = d_oe ? d_ad : h_ad;
    always #2.5 clk_i = ~clk_i;

    erc_ext_regs #(.LEAD_CYC(LEAD), .KS_CYC(KSC)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .ad_i(bus), .ad_o(d_ad), .ad_oe_o(d_oe),
        .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n),
        .bank_select_bit_i(bank), .power_good_signal_i(pgood),
        .aux_battery_pin_ok_i(1'b1), .update_req_i(ureq), .update_done_i(udone),
        .wakeup_match_i(wake), .kickstart_input_n_i(ks_n),
        .ram_clear_input_n_i(ram_clear_input_n), .update_start_o(ustart),
        .user_ram_clear_o(uclr), .power_control_output_o(power_control_output),
        .power_control_output_oe_o(pwr_oe), .irq_o(irq), .irq_oe_o(irq_oe),
        .osc_output_enable_o(osc), .xtal_load_sel_o(xtal), .aux_battery_enable_o(abe));

    erc_host i_host (.clk_i(clk_i), .bus_i(bus), .ad_o(h_ad), .ale_o(ale),
                     .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n));

    task automatic give_verdict();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Byte compare
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask

    // Pin compare
    task automatic chk1(input string s, input logic e, input logic g);
        chk(s, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.acc(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // Hang guard, tests need well under this
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        tick(20);
        rstn_i = 1'b1;
        bank = 1'b1;
        rd(OFS_CTRL_A, RST_CTRL_A | 8'h80);
        rd(OFS_CTRL_B, RST_CTRL_B);
        chk1("pwr_oe", 1'b0, pwr_oe);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        chk1("abe", 1'b1, abe);
        chk1("xtal", 1'b1, xtal);
        wr(OFS_CTRL_B, 8'h00);
        $display("test rows done");
        // Burst across the low byte wrap, then plain repeats
        wr(OFS_CTRL_A, 8'h28);
        wr(OFS_XADR_H, 8'h00);
        wr(OFS_XADR_L, 8'hFF);
        wr(OFS_XDATA, 8'hA1);
        wr(OFS_XDATA, 8'hA2);
        rd(OFS_XADR_L, 8'h01);
        rd(OFS_XADR_H, 8'h01);
        wr(OFS_XADR_L, 8'hFF);
        wr(OFS_XADR_H, 8'h00);
        rd(OFS_XDATA, 8'hA1);
        rd(OFS_XDATA, 8'hA2);
        wr(OFS_CTRL_A, 8'h08);
        wr(OFS_XADR_L, 8'hFF);
        wr(OFS_XADR_H, 8'h00);
        rd(OFS_XDATA, 8'hA1);
        rd(OFS_XDATA, 8'hA1);
        $display("test xram done");
        rd(OFS_XADR_L, 8'hFF);
        rd(OFS_STK_1, OFS_XADR_L);
        rd(OFS_STK_0, OFS_XADR_L);
        $display("test stack done");
        wr(OFS_CTRL_B, 8'h02);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(1);
        chk1("pwr_oe", 1'b1, pwr_oe);
        chk1("irq_oe", 1'b1, irq_oe);
        chk1("pwr", 1'b0, power_control_output);
        chk1("irq", 1'b0, irq);
        rd(OFS_CTRL_A, 8'h82);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_A, 8'h08);
        rd(OFS_CTRL_A, 8'h88);
        chk1("pwr_oe", 1'b0, pwr_oe);
        wr(OFS_CTRL_B, 8'h01);
        ks_n = 1'b0;
        tick(2);
        ks_n = 1'b1;
        tick(2);
        rd(OFS_CTRL_A, 8'h88);
        ks_n = 1'b0;
        tick(KSC + 2);
        ks_n = 1'b1;
        tick(1);
        chk1("irq_oe", 1'b1, irq_oe);
        rd(OFS_CTRL_A, 8'h81);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_A, 8'h08);
        $display("test flags done");
        wr(OFS_CTRL_B, 8'h14);
        ram_clear_input_n = 1'b0;
        tick(2);
        chk1("uclr", 1'b1, uclr);
        ram_clear_input_n = 1'b1;
        tick(1);
        chk1("irq_oe", 1'b1, irq_oe);
        rd(OFS_CTRL_A, 8'h8C);
        wr(OFS_CTRL_A, 8'h08);
        chk1("irq_oe", 1'b0, irq_oe);
        wr(OFS_CTRL_B, 8'h00);
        ram_clear_input_n = 1'b0;
        tick(2);
        chk1("uclr", 1'b0, uclr);
        ram_clear_input_n = 1'b1;
        rd(OFS_CTRL_A, 8'h88);
        $display("test ram clear done");
        ureq = 1'b1;
        tick(1);
        ureq = 1'b0;
        n = 1;
        while (ustart !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("lead", 8'(LEAD + 1), 8'(n));
        rd(OFS_CTRL_A, 8'hC8);
        udone = 1'b1;
        tick(1);
        udone = 1'b0;
        tick(1);
        rd(OFS_CTRL_A, 8'h88);
        $display("test update done");
        wr(OFS_CTRL_A, 8'h00);
        chk1("pwr_oe", 1'b1, pwr_oe);
        pgood = 1'b0;
        tick(2);
        chk1("pwr_oe", 1'b0, pwr_oe);
        pgood = 1'b1;
        tick(2);
        chk1("osc", 1'b1, osc);
        bank = 1'b0;
        wr(OFS_CTRL_B, 8'hFF);
        bank = 1'b1;
        rd(OFS_CTRL_B, 8'h40);
        $display("test power done");
        give_verdict();
    end
endmodule
